// ---- verilog/timer_set_consts.svh ----
// register indices, field positions and fixed counts of the timer set
`ifndef TIMER_SET_CONSTS_SVH
`define TIMER_SET_CONSTS_SVH
// register indices; byte address is four times the index
`define IX_BTCTL  6'h00
`define IX_BTMODE 6'h01
`define IX_CKC    6'h02
`define IX_A_LO   6'h03
`define IX_A_HI   6'h04
`define IX_B_LO   6'h05
`define IX_B_HI   6'h06
`define IX_C_CTL  6'h07
`define IX_C_LO   6'h08
`define IX_C_HI   6'h09
`define IX_C_RL   6'h0a
`define IX_C_RH   6'h0b
`define IX_CAP0L  6'h0c
`define IX_CAP2H  6'h11
`define IX_D_CTL  6'h12
`define IX_D_RL   6'h13
`define IX_D_RH   6'h14
`define IX_IEN    6'h15
// basic_timer_control bits
`define TC_RUN_A  4
`define TC_TF_A   5
`define TC_RUN_B  6
`define TC_TF_B   7
// basic_timer_mode_reg fields
`define MD_A_LSB  0
`define MD_A_CT   2
`define MD_B_LSB  4
`define MD_B_CT   6
// clock_control_reg bits
`define CK_A_TOG  1
`define CK_B_TOG  2
`define CK_A_SYS  3
`define CK_B_SYS  4
// timer_c_control bits
`define C_CMP     0
`define C_RUN     2
`define C_PS_LSB  4
`define C_TF      7
// timer_d_control bits
`define D_PS_LSB  0
`define D_RUN     3
`define D_TF      4
// extended_irq_enable_reg bits
`define IE_A      0
`define IE_D      1
`define IE_B      2
`define IE_C      3
// fixed counts and answers
`define DIV12_LAST 4'hb
`define MODE_SPLIT 2'h3
`define RESP_OKAY  2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- verilog/timer_set_pkg.sv ----
// types shared by the timer set and its bench
package timer_set_pkg;
	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axi_req_type;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_type;
	typedef struct packed {
		logic [2:0] cap;
		logic       b;
		logic       a;
	} pins_in_type;
	typedef struct packed {
		logic a_out;
		logic a_oe;
		logic b_out;
		logic b_oe;
	} pins_out_type;
	typedef struct packed {
		axi_rsp_type        rsp;
		pins_out_type       pins;
		logic               aw_got;
		logic               w_got;
		logic [5:0]         aw_idx;
		logic [7:0]         wbyte;
		logic               wstb;
		logic [4:0]         s1;
		logic [4:0]         s2;
		logic [4:0]         s3;
		logic [4:0]         lvl;
		logic [7:0]         btctl;
		logic [7:0]         btmode;
		logic [7:0]         ckc;
		logic [15:0]        a_cnt;
		logic [15:0]        b_cnt;
		logic [7:0]         c_ctl;
		logic [15:0]        c_cnt;
		logic [15:0]        c_rl;
		logic [2:0][15:0]   cap;
		logic [7:0]         d_ctl;
		logic [15:0]        d_cnt;
		logic [15:0]        d_rl;
		logic [7:0]         ien;
		logic [3:0]         div12;
		logic [6:0]         pre_c;
		logic [6:0]         pre_d;
		logic [3:0]         irq;
		logic               baud_tick;
	} state_type;
endpackage

// ---- verilog/general_timer_set.sv ----
// four general timers with an axi4-lite register slave
`include "timer_set_consts.svh"
module general_timer_set (
	// clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// register bus
	input  wire timer_set_pkg::axi_req_type s_axi_req,
	output      timer_set_pkg::axi_rsp_type s_axi_rsp,
	// pins
	input  wire timer_set_pkg::pins_in_type pins_in,
	output      timer_set_pkg::pins_out_type pins_out,
	// service entry (a, b, c, d) and requests
	input  wire logic [3:0]                 isr_enter,
	output      logic [3:0]                 irq,
	output      logic                       baud_tick
);
	import timer_set_pkg::*;

	state_type   r;
	state_type   n;
	logic        wr_en;
	logic        tick12;
	logic        tick_a;
	logic        tick_b;
	logic        tick_c;
	logic        tick_d;
	logic        ovf_a;
	logic        ovf_b;
	logic        ovf_ah;
	logic        ovf_d;
	logic        set_c;
	logic [4:0]  stab;
	logic [4:0]  fall;
	logic [4:0]  rise;
	logic [5:0]  ridx;
	logic [7:0]  rbyte;
	logic [2:0]  cap_sel;

	// word index of a byte address
	function automatic logic [5:0] reg_index(input logic [7:0] addr);
		reg_index = addr[7:2];
	endfunction

	// prescaler hit for ratios 1..128
	function automatic logic pre_hit(input logic [6:0] cnt,
		input logic [2:0] ps);
		logic [6:0] mask;
		mask = 7'((8'h01 << ps) - 8'h01);
		pre_hit = (cnt & mask) == mask;
	endfunction

	// one count step of a basic unit: {overflow, count}
	function automatic logic [16:0] basic_step(input logic [1:0] mode,
		input logic [15:0] cnt);
		logic [13:0] c13;
		logic [8:0]  c8;
		basic_step = {1'b0, cnt};
		c13 = {1'b0, cnt[15:8], cnt[4:0]} + 14'h1;
		c8 = {1'b0, cnt[7:0]} + 9'h1;
		case (mode)
			2'h0: basic_step = {c13[13], c13[12:5], cnt[7:5], c13[4:0]};
			2'h1: basic_step = {1'b0, cnt} + 17'h1;
			2'h2: basic_step = {c8[8], cnt[15:8],
				c8[8] ? cnt[15:8] : c8[7:0]};
			default: basic_step = {c8[8], cnt[15:8], c8[7:0]};
		endcase
	endfunction

	// next state of all timers and the bus slave
	always_comb begin
		n = r;
		ovf_a = 1'b0;
		ovf_b = 1'b0;
		ovf_ah = 1'b0;
		ovf_d = 1'b0;
		set_c = 1'b0;
		// pins pass three flops; a level counts once stages 2 and 3 agree
		n.s1 = pins_in;
		n.s2 = r.s1;
		n.s3 = r.s2;
		stab = ~(r.s2 ^ r.s3);
		n.lvl = (r.s3 & stab) | (r.lvl & ~stab);
		fall = r.lvl & ~n.lvl;
		rise = ~r.lvl & n.lvl;
		// divide-by-twelve tick shared by both basic units
		tick12 = r.div12 == `DIV12_LAST;
		n.div12 = tick12 ? 4'h0 : r.div12 + 4'h1;
		// basic unit a, counter or timer function
		tick_a = r.btctl[`TC_RUN_A] & (r.btmode[`MD_A_CT] ? fall[0] :
			(r.ckc[`CK_A_SYS] | tick12));
		if (tick_a)
			{ovf_a, n.a_cnt} = basic_step(r.btmode[`MD_A_LSB +: 2],
				r.a_cnt);
		// split mode: unit a high byte runs on unit b run and clock
		if (r.btmode[`MD_A_LSB +: 2] == `MODE_SPLIT && r.btctl[`TC_RUN_B] &&
			(r.ckc[`CK_B_SYS] | tick12))
			{ovf_ah, n.a_cnt[15:8]} = {1'b0, r.a_cnt[15:8]} + 9'h1;
		// basic unit b, halted in split mode
		tick_b = r.btctl[`TC_RUN_B] &
			(r.btmode[`MD_B_LSB +: 2] != `MODE_SPLIT) &
			(r.btmode[`MD_B_CT] ? fall[1] : (r.ckc[`CK_B_SYS] | tick12));
		if (tick_b)
			{ovf_b, n.b_cnt} = basic_step(r.btmode[`MD_B_LSB +: 2],
				r.b_cnt);
		// toggle outputs: high while enabled until an overflow inverts them
		n.pins.a_oe = r.ckc[`CK_A_TOG];
		n.pins.b_oe = r.ckc[`CK_B_TOG];
		if (!r.ckc[`CK_A_TOG])
			n.pins.a_out = 1'b1;
		else if (ovf_a)
			n.pins.a_out = ~r.pins.a_out;
		if (!r.ckc[`CK_B_TOG])
			n.pins.b_out = 1'b1;
		else if (ovf_b)
			n.pins.b_out = ~r.pins.b_out;
		// timer c: gated prescaler, compare or auto-reload
		n.pre_c = r.c_ctl[`C_RUN] ? r.pre_c + 7'h1 : 7'h0;
		tick_c = r.c_ctl[`C_RUN] &
			pre_hit(r.pre_c, r.c_ctl[`C_PS_LSB +: 3]);
		if (tick_c) begin
			n.c_cnt = r.c_cnt + 16'h1;
			if (r.c_ctl[`C_CMP]) begin
				set_c = r.c_cnt == r.c_rl;
			end else if (r.c_cnt == 16'hffff) begin
				n.c_cnt = r.c_rl;
				set_c = 1'b1;
			end
		end
		// captures latch the count on a rising capture input
		for (int k = 0; k < 3; k++) begin
			if (rise[2 + k])
				n.cap[k] = r.c_cnt;
		end
		// timer d: prescaled auto-reload, doubles as baud source
		n.pre_d = r.d_ctl[`D_RUN] ? r.pre_d + 7'h1 : 7'h0;
		tick_d = r.d_ctl[`D_RUN] &
			pre_hit(r.pre_d, r.d_ctl[`D_PS_LSB +: 3]);
		if (tick_d) begin
			ovf_d = r.d_cnt == 16'hffff;
			n.d_cnt = ovf_d ? r.d_rl : r.d_cnt + 16'h1;
		end
		n.baud_tick = ovf_d;
		// service entry clears flags before software and hardware act
		if (isr_enter[0])
			n.btctl[`TC_TF_A] = 1'b0;
		if (isr_enter[1])
			n.btctl[`TC_TF_B] = 1'b0;
		if (isr_enter[2])
			n.c_ctl[`C_TF] = 1'b0;
		if (isr_enter[3])
			n.d_ctl[`D_TF] = 1'b0;
		// register write; each count byte written on its own
		wr_en = r.aw_got & r.w_got & ~r.rsp.bvalid;
		if (wr_en && r.wstb) begin
			case (r.aw_idx)
				`IX_BTCTL:  n.btctl = r.wbyte;
				`IX_BTMODE: n.btmode = r.wbyte;
				`IX_CKC:    n.ckc = r.wbyte;
				`IX_A_LO:   n.a_cnt[7:0] = r.wbyte;
				`IX_A_HI:   n.a_cnt[15:8] = r.wbyte;
				`IX_B_LO:   n.b_cnt[7:0] = r.wbyte;
				`IX_B_HI:   n.b_cnt[15:8] = r.wbyte;
				`IX_C_CTL:  n.c_ctl = r.wbyte;
				`IX_C_LO:   n.c_cnt[7:0] = r.wbyte;
				`IX_C_HI:   n.c_cnt[15:8] = r.wbyte;
				`IX_C_RL:   n.c_rl[7:0] = r.wbyte;
				`IX_C_RH:   n.c_rl[15:8] = r.wbyte;
				`IX_D_CTL:  n.d_ctl = r.wbyte;
				`IX_D_RL:   n.d_rl[7:0] = r.wbyte;
				`IX_D_RH:   n.d_rl[15:8] = r.wbyte;
				`IX_IEN:    n.ien = r.wbyte;
				default:    n.ien = n.ien;
			endcase
		end
		// hardware sets win over any clear in the same cycle
		n.btctl[`TC_TF_A] = n.btctl[`TC_TF_A] | ovf_a;
		n.btctl[`TC_TF_B] = n.btctl[`TC_TF_B] | ovf_b | ovf_ah;
		n.c_ctl[`C_TF] = n.c_ctl[`C_TF] | set_c;
		n.d_ctl[`D_TF] = n.d_ctl[`D_TF] | ovf_d;
		// interrupt requests follow flag and enable
		n.irq[0] = n.btctl[`TC_TF_A] & n.ien[`IE_A];
		n.irq[1] = n.btctl[`TC_TF_B] & n.ien[`IE_B];
		n.irq[2] = n.c_ctl[`C_TF] & n.ien[`IE_C];
		n.irq[3] = n.d_ctl[`D_TF] & n.ien[`IE_D];
		// write channels: address and data in either order
		if (s_axi_req.awvalid && r.rsp.awready) begin
			n.aw_got = 1'b1;
			n.aw_idx = reg_index(s_axi_req.awaddr);
		end
		if (s_axi_req.wvalid && r.rsp.wready) begin
			n.w_got = 1'b1;
			n.wbyte = s_axi_req.wdata[7:0];
			n.wstb = s_axi_req.wstrb[0];
		end
		if (wr_en) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.rsp.bvalid = 1'b1;
			n.rsp.bresp = (r.aw_idx <= `IX_IEN) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (r.rsp.bvalid && s_axi_req.bready) begin
			n.rsp.bvalid = 1'b0;
		end
		n.rsp.awready = ~n.aw_got & ~n.rsp.bvalid;
		n.rsp.wready = ~n.w_got & ~n.rsp.bvalid;
		// read channel
		ridx = reg_index(s_axi_req.araddr);
		case (ridx)
			`IX_BTCTL:  rbyte = r.btctl;
			`IX_BTMODE: rbyte = r.btmode;
			`IX_CKC:    rbyte = r.ckc;
			`IX_A_LO:   rbyte = r.a_cnt[7:0];
			`IX_A_HI:   rbyte = r.a_cnt[15:8];
			`IX_B_LO:   rbyte = r.b_cnt[7:0];
			`IX_B_HI:   rbyte = r.b_cnt[15:8];
			`IX_C_CTL:  rbyte = r.c_ctl;
			`IX_C_LO:   rbyte = r.c_cnt[7:0];
			`IX_C_HI:   rbyte = r.c_cnt[15:8];
			`IX_C_RL:   rbyte = r.c_rl[7:0];
			`IX_C_RH:   rbyte = r.c_rl[15:8];
			`IX_D_CTL:  rbyte = r.d_ctl;
			`IX_D_RL:   rbyte = r.d_rl[7:0];
			`IX_D_RH:   rbyte = r.d_rl[15:8];
			`IX_IEN:    rbyte = r.ien;
			default:    rbyte = 8'h00;
		endcase
		// capture pairs: low byte at an even distance from the first index
		cap_sel = 3'(ridx - `IX_CAP0L);
		if (ridx >= `IX_CAP0L && ridx <= `IX_CAP2H) begin
			rbyte = cap_sel[0] ? r.cap[cap_sel[2:1]][15:8] :
				r.cap[cap_sel[2:1]][7:0];
		end
		if (s_axi_req.arvalid && r.rsp.arready) begin
			n.rsp.rvalid = 1'b1;
			n.rsp.rdata = {24'h0, rbyte};
			n.rsp.rresp = (ridx <= `IX_IEN) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (r.rsp.rvalid && s_axi_req.rready) begin
			n.rsp.rvalid = 1'b0;
		end
		n.rsp.arready = ~n.rsp.rvalid;
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			r <= '0;
		else
			r <= n;
	end

	// outputs straight from the state register
	assign s_axi_rsp = r.rsp;
	assign pins_out = r.pins;
	assign irq = r.irq;
	assign baud_tick = r.baud_tick;

	// checks on the timer behaviour
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_EDGE_COUNT: assert property (
		tick_a |-> r.btctl[`TC_RUN_A] &&
			(!r.btmode[`MD_A_CT] || (r.lvl[0] && !n.lvl[0])))
		else $error("unit a counted without a falling pin edge");
	AST_SYS_CLOCK: assert property (
		r.btctl[`TC_RUN_A] && !r.btmode[`MD_A_CT] && r.ckc[`CK_A_SYS] &&
			r.btmode[`MD_A_LSB +: 2] == 2'h1 && !wr_en
			|=> r.a_cnt == 16'($past(r.a_cnt) + 16'h1))
		else $error("unit a missed a system clock count");
	AST_TOGGLE_FLIP: assert property (
		ovf_a && r.ckc[`CK_A_TOG] |=> r.pins.a_out != $past(r.pins.a_out))
		else $error("toggle pin did not invert on overflow");
	AST_TOGGLE_START: assert property (
		$rose(r.pins.a_oe) |-> r.pins.a_out || $past(ovf_a))
		else $error("toggle pin not high when enabled");
	AST_C_GATE: assert property (
		(!r.c_ctl[`C_RUN] && !wr_en) [*2] |-> $stable(r.c_cnt))
		else $error("timer c moved while stopped");
	AST_CAPTURE: assert property (
		rise[2] |=> r.cap[0] == $past(r.c_cnt))
		else $error("capture zero missed the count");
	AST_D_RELOAD: assert property (
		ovf_d |=> r.d_cnt == $past(r.d_rl) && r.d_ctl[`D_TF] && r.baud_tick)
		else $error("timer d rollover did not reload and flag");
	AST_D_STOP: assert property (
		!r.d_ctl[`D_RUN] |-> !tick_d ##1 (!wr_en || r.aw_idx != `IX_D_CTL)
			|-> $stable(r.d_cnt))
		else $error("timer d counted while stopped");
	AST_D_IRQ: assert property (
		ovf_d && r.ien[`IE_D] && (!wr_en || r.aw_idx != `IX_IEN) |=> irq[3])
		else $error("timer d overflow raised no request");
	AST_D_ACK: assert property (
		isr_enter[3] && !ovf_d && (!wr_en || r.aw_idx != `IX_D_CTL)
			|=> !r.d_ctl[`D_TF])
		else $error("timer d flag survived service entry");
endmodule

// ---- bench/timer_pin_model.sv ----
// far-side model of the timer count, capture and toggle pins
module timer_pin_model
	import timer_set_pkg::*;
(
	// clock
	input  wire logic                        aclk,
	// device side of the pins
	input  wire timer_set_pkg::pins_out_type pins_out,
	output      timer_set_pkg::pins_in_type  pins_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       a_drv   = 1'b1;
	logic [2:0] cap_drv = 3'h0;
	// count and toggle pins idle high, capture pins idle low; the device wins wherever it drives
	assign pins_in = '{cap: cap_drv,
		b: pins_out.b_oe ? pins_out.b_out : 1'b1,
		a: pins_out.a_oe ? pins_out.a_out : a_drv};
	// falling edges on the count pin, each level held past the filter
	task automatic pulse_a(input int n);
		repeat (n) begin
			@(posedge aclk);
			a_drv <= 1'b0;
			repeat (8) @(posedge aclk);
			a_drv <= 1'b1;
			repeat (8) @(posedge aclk);
		end
	endtask
	// one rising edge on a capture input
	task automatic pulse_cap(input int k);
		@(posedge aclk);
		cap_drv[k] <= 1'b1;
		repeat (8) @(posedge aclk);
		cap_drv[k] <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask
endmodule

// ---- bench/test_general_timer_set.sv ----
// self-checking bench for the general timer set
`include "timer_set_consts.svh"
`define CHK(what, exp, got) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) begin \
			miscompares++; \
			$display("ERROR %s expected %h seen %h", what, exp, got); \
		end \
	end
module test_general_timer_set
	import timer_set_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         aclk;
	logic         aresetn;
	axi_req_type  req;
	axi_rsp_type  rsp;
	pins_in_type  pin_i;
	pins_out_type pin_o;
	logic [3:0]   isr_enter;
	logic [3:0]   irq;
	logic         baud_tick;
	int           miscompares;
	int           checks_done;
	// device and its pin partner
	general_timer_set i_dut (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.s_axi_req (req),
		.s_axi_rsp (rsp),
		.pins_in   (pin_i),
		.pins_out  (pin_o),
		.isr_enter (isr_enter),
		.irq       (irq),
		.baud_tick (baud_tick)
	);
	timer_pin_model i_pins (
		.aclk     (aclk),
		.pins_out (pin_o),
		.pins_in  (pin_i)
	);
	// 125 mhz clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// register write: address and data together, each released when taken
	task automatic axw(input logic [5:0] ix, input logic [7:0] d);
		req.awaddr  <= {ix, 2'b00};
		req.wdata   <= {24'h0, d};
		req.wstrb   <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid  <= 1'b1;
		do begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
	endtask
	// register read; ready lines stay high throughout
	task automatic axr(input logic [5:0] ix, output logic [31:0] d,
		output logic [1:0] r);
		req.araddr  <= {ix, 2'b00};
		req.arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
	endtask
	// read one register and compare with an okay answer
	task automatic rchk(input logic [5:0] ix, input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axr(ix, d, r);
		`CHK("register read", {24'h0, exp}, d)
		`CHK("read response", `RESP_OKAY, r)
	endtask
	// reset values and an unmapped index
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		rchk(`IX_BTCTL, 8'h00);
		rchk(`IX_D_CTL, 8'h00);
		axr(6'h16, d, r);
		`CHK("unmapped response", `RESP_SLVERR, r)
	endtask
	// counter function: pin edges carry from low byte into high byte
	task automatic t_count();
		axw(`IX_BTMODE, 8'h05);
		axw(`IX_A_LO, 8'hfe);
		axw(`IX_A_HI, 8'h00);
		axw(`IX_BTCTL, 8'h10);
		i_pins.pulse_a(3);
		axw(`IX_BTCTL, 8'h00);
		rchk(`IX_A_LO, 8'h01);
		rchk(`IX_A_HI, 8'h01);
	endtask
	// toggle output: high until the first overflow, then inverted
	task automatic t_toggle();
		axw(`IX_IEN, 8'h03);
		axw(`IX_BTMODE, 8'h01);
		axw(`IX_A_LO, 8'hf0);
		axw(`IX_A_HI, 8'hff);
		axw(`IX_CKC, 8'h0a);
		repeat (2) @(posedge aclk);
		`CHK("toggle idle", 1'b1, pin_o.a_out & pin_o.a_oe)
		axw(`IX_BTCTL, 8'h10);
		repeat (40) @(posedge aclk);
		`CHK("toggle pin", 1'b0, pin_o.a_out)
		`CHK("irq a", 1'b1, irq[0])
		axw(`IX_BTCTL, 8'h00);
		axw(`IX_CKC, 8'h00);
	endtask
	// stopped timer c: each capture channel stores the held count
	task automatic t_capture();
		axw(`IX_C_LO, 8'h5a);
		axw(`IX_C_HI, 8'h3c);
		for (int k = 0; k < 3; k++) begin
			i_pins.pulse_cap(k);
			rchk(6'(`IX_CAP0L + 2 * k), 8'h5a);
			rchk(6'(`IX_CAP0L + 2 * k + 1), 8'h3c);
		end
		rchk(`IX_C_LO, 8'h5a);
	endtask
	// timer d: reload, flag, service clear and baud period
	task automatic t_timer_d();
		int n;
		axw(`IX_D_RL, 8'hf0);
		axw(`IX_D_RH, 8'hff);
		axw(`IX_D_CTL, 8'h08);
		while (irq[3] !== 1'b1) @(posedge aclk);
		rchk(`IX_D_CTL, 8'h18);
		axw(`IX_D_CTL, 8'h17);
		isr_enter <= 4'h8;
		@(posedge aclk);
		isr_enter <= 4'h0;
		rchk(`IX_D_CTL, 8'h07);
		`CHK("irq d", 1'b0, irq[3])
		axw(`IX_D_CTL, 8'h0f);
		while (baud_tick !== 1'b1) @(posedge aclk);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (baud_tick !== 1'b1);
		`CHK("baud period", 2048, n)
	endtask
	// unit b: 8-bit reload on the divided clock, toggling its pin
	task automatic t_unit_b();
		int n;
		axw(`IX_IEN, 8'h04);
		axw(`IX_BTMODE, 8'h20);
		axw(`IX_B_HI, 8'hfe);
		axw(`IX_B_LO, 8'hfc);
		axw(`IX_CKC, 8'h04);
		repeat (2) @(posedge aclk);
		`CHK("toggle b idle", 1'b1, pin_o.b_out & pin_o.b_oe)
		axw(`IX_BTCTL, 8'h40);
		while (irq[1] !== 1'b1) @(posedge aclk);
		`CHK("toggle b pin", 1'b0, pin_o.b_out)
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (pin_o.b_out !== 1'b1);
		`CHK("divided reload period", 24, n)
		rchk(`IX_BTCTL, 8'hc0);
		axw(`IX_BTCTL, 8'h00);
		rchk(`IX_B_LO, 8'hfe);
		axw(`IX_CKC, 8'h00);
	endtask
	// timer c: prescaled auto-reload, then a compare match
	task automatic t_timer_c();
		int n;
		axw(`IX_IEN, 8'h08);
		axw(`IX_C_RL, 8'hfc);
		axw(`IX_C_RH, 8'hff);
		axw(`IX_C_LO, 8'hfc);
		axw(`IX_C_HI, 8'hff);
		axw(`IX_C_CTL, 8'h14);
		while (irq[2] !== 1'b1) @(posedge aclk);
		isr_enter <= 4'h4;
		@(posedge aclk);
		isr_enter <= 4'h0;
		n = 1;
		do begin
			@(posedge aclk);
			n++;
		end while (irq[2] !== 1'b1);
		`CHK("timer c reload period", 8, n)
		axw(`IX_C_CTL, 8'h00);
		axw(`IX_C_LO, 8'h00);
		axw(`IX_C_HI, 8'h00);
		axw(`IX_C_RL, 8'h03);
		axw(`IX_C_RH, 8'h00);
		axw(`IX_C_CTL, 8'h15);
		repeat (20) @(posedge aclk);
		rchk(`IX_C_CTL, 8'h95);
		`CHK("irq c", 1'b1, irq[2])
		axw(`IX_C_CTL, 8'h00);
	endtask
	// verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		repeat (90000) @(posedge aclk);
		miscompares++;
		wrap_up();
	end
	// main sequence
	initial begin
		aresetn   = 1'b0;
		req       = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		isr_enter = 4'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_count();
		t_toggle();
		t_capture();
		t_timer_d();
		t_unit_b();
		t_timer_c();
		wrap_up();
	end
endmodule
